/* File: verilog/adc_input_select_timing.sv */
// Converter input select, reference select and stage sequencer with Avalon-MM registers.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps

// Functional notes
// - Reference code 11 fixed reference, 10 external pin, 00 supply; 01 reserved.
// - Positive top codes 111001-111111 select the seven internal sources.
// - Reserved channel codes on either side connect nothing.
// - Positive codes 000000-000101 and 001100-010111 are pins; 000011 ground sense.
// - Negative side uses the same pins; its code 000011 connects nothing.
// - Negative codes 111001-111111 map to the same internal sources.
// - Nonzero precharge count n lasts n system or RC clock periods.
// - Zero precharge count drops the precharge stage.
// - Nonzero acquisition count n lasts n periods of the chosen clock.
// - Zero acquisition gives 8192 clocks after precharge, none without it.
// - Precharge count reads and writes as high byte 12:8 and low byte 7:0.
// - Acquisition count likewise as two bytes; unused upper bits read zero.
// - After reset both channel selects and both counts are zero.
module adc_input_select_timing
	import adc_select_pkg::*;
#(
	parameter int CONVERT_CYCLES = 16
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire logic [15:0]           address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [3:0]            byteenable,
	input  wire logic [31:0]           writedata,
	output logic [31:0]                readdata,
	output logic                       waitrequest,
	input  wire logic                  dedicated_rc_clock,
	output logic                       vref_to_supply,
	output logic                       vref_to_external,
	output logic                       vref_to_fixed,
	output logic                       pos_pin_enable,
	output logic [4:0]                 pos_pin_index,
	output logic                       pos_ground_sense,
	output logic [INTERNAL_N-1:0]      pos_internal_enable,
	output logic                       neg_pin_enable,
	output logic [4:0]                 neg_pin_index,
	output logic [INTERNAL_N-1:0]      neg_internal_enable,
	output logic                       precharge_active,
	output logic                       sample_active,
	output logic                       convert_active,
	output logic                       cycle_done
);

	// ------------------------------------------------------------------
	// Reset release.
	// ------------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------
	logic [CHANNEL_W-1:0] pos_input_select_q;
	logic [CHANNEL_W-1:0] neg_input_select_q;
	logic [COUNT_W-1:0]   precharge_count_q;
	logic [COUNT_W-1:0]   acquisition_count_q;
	logic [REF_W-1:0]     vref_pos_select_q;
	logic                 go_q;
	logic                 rc_select_q;
	logic                 resp_q;
	logic [31:0]          readdata_q;
	logic [13:0]          index;
	logic                 request;
	logic                 wr_commit;

	seq_state_type        state_q;
	seq_state_type        state_d;
	logic [COUNT_W-1:0]   run_precharge_q;
	logic [COUNT_W-1:0]   run_acquisition_q;
	logic                 run_rc_q;
	logic                 rc_last_q;
	logic                 tick;
	logic                 timer_load;
	logic [STAGE_W-1:0]   timer_length;
	logic                 timer_done;
	logic [7:0]           convert_q;
	logic                 convert_last;

	logic                 pos_pin_d;
	logic [4:0]           pos_index_d;
	logic                 pos_gs_d;
	logic [INTERNAL_N-1:0] pos_int_d;
	logic                 neg_pin_d;
	logic [4:0]           neg_index_d;
	logic [INTERNAL_N-1:0] neg_int_d;

	// ------------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------------

	// Merges the two byte lanes of a count write; bits above 12 are dropped.
	function automatic logic [COUNT_W-1:0] merge_count(
		input logic [COUNT_W-1:0] old_value,
		input logic [3:0]         lanes,
		input logic [31:0]        data
	);
		logic [COUNT_W-1:0] result;
		result = old_value;
		if (lanes[0]) begin
			result[HIGH_LSB-1:0] = data[7:0];
		end
		if (lanes[1]) begin
			result[HIGH_MSB:HIGH_LSB] = data[HIGH_MSB:HIGH_LSB];
		end
		return result;
	endfunction

	// Widens a count to the stage timer width.
	function automatic logic [STAGE_W-1:0] widen(input logic [COUNT_W-1:0] value);
		return {1'b0, value};
	endfunction

	// ------------------------------------------------------------------
	// Avalon-MM slave: one wait cycle on every access after reset while clk_en stays high.
	// ------------------------------------------------------------------
	assign index       = address[15:2];
	assign request     = (read || write) && rst_sync_n;
	assign waitrequest = request && !(resp_q && clk_en);
	assign wr_commit   = write && resp_q && clk_en;
	assign readdata    = readdata_q;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			resp_q <= 1'b0;
		end else if (clk_en) begin
			resp_q <= request && !resp_q;
		end
	end

	// Read data is captured while waitrequest is high and stands at the answer edge.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			readdata_q <= '0;
		end else if (clk_en && read && !resp_q) begin
			readdata_q <= '0;
			if (index == IDX_POS_CHANNEL) begin
				readdata_q[CHANNEL_W-1:0] <= pos_input_select_q;
			end else if (index == IDX_NEG_CHANNEL) begin
				readdata_q[CHANNEL_W-1:0] <= neg_input_select_q;
			end else if (index == IDX_ACQUISITION) begin
				readdata_q[COUNT_W-1:0] <= acquisition_count_q;
			end else if (index == IDX_PRECHARGE) begin
				readdata_q[COUNT_W-1:0] <= precharge_count_q;
			end else if (index == IDX_REFERENCE) begin
				readdata_q[REF_W-1:0] <= vref_pos_select_q;
			end else if (index == IDX_CONTROL) begin
				readdata_q[CTRL_GO]    <= go_q;
				readdata_q[CTRL_RCSEL] <= rc_select_q;
			end else if (index == IDX_STATUS) begin
				readdata_q[1:0]       <= state_q;
				readdata_q[STAT_BUSY] <= state_q != SEQ_IDLE;
			end
		end
	end

	// ------------------------------------------------------------------
	// Settings registers.
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pos_input_select_q <= CHANNEL_RESET;
			neg_input_select_q <= CHANNEL_RESET;
		end else if (wr_commit && byteenable[0]) begin
			if (index == IDX_POS_CHANNEL) begin
				pos_input_select_q <= writedata[CHANNEL_W-1:0];
			end else if (index == IDX_NEG_CHANNEL) begin
				neg_input_select_q <= writedata[CHANNEL_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			precharge_count_q   <= COUNT_RESET;
			acquisition_count_q <= COUNT_RESET;
		end else if (wr_commit) begin
			if (index == IDX_PRECHARGE) begin
				precharge_count_q <= merge_count(precharge_count_q, byteenable,
					writedata);
			end else if (index == IDX_ACQUISITION) begin
				acquisition_count_q <= merge_count(acquisition_count_q, byteenable,
					writedata);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			vref_pos_select_q <= REF_RESET;
		end else if (wr_commit && byteenable[0] && index == IDX_REFERENCE) begin
			vref_pos_select_q <= writedata[REF_W-1:0];
		end
	end

	// Start bit: a write of one starts a cycle; hardware clears it at the end.
	// A new start written in the finishing cycle wins over the clear.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			go_q        <= 1'b0;
			rc_select_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_commit && byteenable[0] && index == IDX_CONTROL) begin
				go_q        <= writedata[CTRL_GO] || (go_q && !cycle_done);
				rc_select_q <= writedata[CTRL_RCSEL];
			end else if (cycle_done) begin
				go_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Timing clock selection.
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rc_last_q <= 1'b0;
		end else if (clk_en) begin
			rc_last_q <= dedicated_rc_clock;
		end
	end

	// Each system clock is one period, or each rising edge of the RC clock.
	// The RC clock must run slower than half the system clock to be counted.
	assign tick = clk_en && (!run_rc_q || (dedicated_rc_clock && !rc_last_q));

	// ------------------------------------------------------------------
	// Stage sequencer.
	// ------------------------------------------------------------------
	assign convert_last = convert_q == 8'(CONVERT_CYCLES - 1);

	always_comb begin
		state_d      = state_q;
		timer_load   = 1'b0;
		timer_length = '0;
		case (state_q)
			SEQ_IDLE: begin
				if (go_q) begin
					timer_load = 1'b1;
					if (precharge_count_q != '0) begin
						state_d      = SEQ_PRECHARGE;
						timer_length = widen(precharge_count_q);
					end else if (acquisition_count_q != '0) begin
						state_d      = SEQ_ACQUIRE;
						timer_length = widen(acquisition_count_q);
					end else begin
						state_d = SEQ_CONVERT;
					end
				end
			end
			SEQ_PRECHARGE: begin
				if (timer_done) begin
					state_d    = SEQ_ACQUIRE;
					timer_load = 1'b1;
					if (run_acquisition_q == '0) begin
						timer_length = ACQUISITION_DEFAULT;
					end else begin
						timer_length = widen(run_acquisition_q);
					end
				end
			end
			SEQ_ACQUIRE: begin
				if (timer_done) begin
					state_d = SEQ_CONVERT;
				end
			end
			SEQ_CONVERT: begin
				if (convert_last) begin
					state_d = SEQ_IDLE;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_q <= SEQ_IDLE;
		end else if (clk_en) begin
			state_q <= state_d;
		end
	end

	// Settings are frozen at the start so software writes cannot stretch a stage.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			run_precharge_q   <= COUNT_RESET;
			run_acquisition_q <= COUNT_RESET;
			run_rc_q          <= 1'b0;
		end else if (clk_en && state_q == SEQ_IDLE && go_q) begin
			run_precharge_q   <= precharge_count_q;
			run_acquisition_q <= acquisition_count_q;
			run_rc_q          <= rc_select_q;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			convert_q <= '0;
		end else if (clk_en) begin
			if (state_q == SEQ_CONVERT && !convert_last) begin
				convert_q <= convert_q + 8'h01;
			end else begin
				convert_q <= '0;
			end
		end
	end

	stage_timer u_stage_timer (
		.clk        (clk),
		.rst_sync_n (rst_sync_n),
		.clk_en     (clk_en),
		.load       (timer_load),
		.length     (timer_length),
		.tick       (tick),
		.done       (timer_done)
	);

	assign precharge_active = state_q == SEQ_PRECHARGE;
	assign sample_active    = state_q == SEQ_ACQUIRE;
	assign convert_active   = state_q == SEQ_CONVERT;
	assign cycle_done       = clk_en && state_q == SEQ_CONVERT && convert_last;

	// ------------------------------------------------------------------
	// Analog switch controls, registered.
	// ------------------------------------------------------------------
	channel_decode #(
		.NEGATIVE_SIDE (1'b0)
	) u_pos_decode (
		.code            (pos_input_select_q),
		.pin_enable      (pos_pin_d),
		.pin_index       (pos_index_d),
		.ground_sense    (pos_gs_d),
		.internal_enable (pos_int_d)
	);

	channel_decode #(
		.NEGATIVE_SIDE (1'b1)
	) u_neg_decode (
		.code            (neg_input_select_q),
		.pin_enable      (neg_pin_d),
		.pin_index       (neg_index_d),
		.ground_sense    (),
		.internal_enable (neg_int_d)
	);

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pos_pin_enable      <= 1'b0;
			pos_pin_index       <= '0;
			pos_ground_sense    <= 1'b0;
			pos_internal_enable <= '0;
			neg_pin_enable      <= 1'b0;
			neg_pin_index       <= '0;
			neg_internal_enable <= '0;
		end else if (clk_en) begin
			pos_pin_enable      <= pos_pin_d;
			pos_pin_index       <= pos_index_d;
			pos_ground_sense    <= pos_gs_d;
			pos_internal_enable <= pos_int_d;
			neg_pin_enable      <= neg_pin_d;
			neg_pin_index       <= neg_index_d;
			neg_internal_enable <= neg_int_d;
		end
	end

	// Reserved reference code opens all three switches.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			vref_to_supply   <= 1'b0;
			vref_to_external <= 1'b0;
			vref_to_fixed    <= 1'b0;
		end else if (clk_en) begin
			vref_to_supply   <= vref_pos_select_q == REF_SUPPLY;
			vref_to_external <= vref_pos_select_q == REF_EXTERNAL;
			vref_to_fixed    <= vref_pos_select_q == REF_FIXED;
		end
	end

endmodule

/* File: verilog/adc_select_pkg.sv */
// Shared constants for the converter input select and stage timing block.
package adc_select_pkg;

	// ------------------------------------------------------------------
	// Register indices; byte address is four times the index.
	// ------------------------------------------------------------------
	localparam logic [13:0] IDX_POS_CHANNEL = 14'h1d1f;
	localparam logic [13:0] IDX_NEG_CHANNEL = 14'h1d20;
	localparam logic [13:0] IDX_ACQUISITION = 14'h1d21;
	localparam logic [13:0] IDX_PRECHARGE   = 14'h1d24;
	localparam logic [13:0] IDX_REFERENCE   = 14'h1d2b;
	localparam logic [13:0] IDX_CONTROL     = 14'h1d30;
	localparam logic [13:0] IDX_STATUS      = 14'h1d31;

	// ------------------------------------------------------------------
	// Field layouts.
	// ------------------------------------------------------------------
	localparam int CHANNEL_W  = 6;
	localparam int COUNT_W    = 13;
	localparam int STAGE_W    = 14;
	localparam int REF_W      = 2;
	localparam int HIGH_LSB   = 8;
	localparam int HIGH_MSB   = 12;
	localparam int CTRL_GO    = 0;
	localparam int CTRL_RCSEL = 1;
	localparam int STAT_BUSY  = 2;

	// ------------------------------------------------------------------
	// Reset values.
	// ------------------------------------------------------------------
	localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 6'h00;
	localparam logic [COUNT_W-1:0]   COUNT_RESET   = 13'h0000;
	localparam logic [REF_W-1:0]     REF_RESET     = 2'h0;

	// ------------------------------------------------------------------
	// Encodings.
	// ------------------------------------------------------------------
	localparam logic [REF_W-1:0] REF_SUPPLY   = 2'h0;
	localparam logic [REF_W-1:0] REF_EXTERNAL = 2'h2;
	localparam logic [REF_W-1:0] REF_FIXED    = 2'h3;

	localparam logic [CHANNEL_W-1:0] CH_GROUND_SENSE = 6'h03;
	localparam logic [CHANNEL_W-1:0] CH_PORTA_LAST   = 6'h05;
	localparam logic [CHANNEL_W-1:0] CH_PORTB_FIRST  = 6'h0c;
	localparam logic [CHANNEL_W-1:0] CH_PORTC_LAST   = 6'h17;
	localparam logic [CHANNEL_W-1:0] CH_INTERNAL_LO  = 6'h39;
	localparam int                   INTERNAL_N      = 7;

	// Acquisition length used when its count is zero but precharge is not.
	localparam logic [STAGE_W-1:0] ACQUISITION_DEFAULT = 14'h2000;

	localparam logic [1:0] STAGE_IDLE      = 2'h0;
	localparam logic [1:0] STAGE_PRECHARGE = 2'h1;
	localparam logic [1:0] STAGE_ACQUIRE   = 2'h2;
	localparam logic [1:0] STAGE_CONVERT   = 2'h3;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_PRECHARGE,
		SEQ_ACQUIRE,
		SEQ_CONVERT
	} seq_state_type;

endpackage

/* File: verilog/channel_decode.sv */
// Decodes a six-bit channel code into analog switch controls.
`timescale 1ns/1ps
module channel_decode
	import adc_select_pkg::*;
#(
	parameter bit NEGATIVE_SIDE = 1'b0
) (
	input  wire logic [CHANNEL_W-1:0]  code,
	output logic                       pin_enable,
	output logic [4:0]                 pin_index,
	output logic                       ground_sense,
	output logic [INTERNAL_N-1:0]      internal_enable
);

	always_comb begin
		pin_enable      = 1'b0;
		pin_index       = code[4:0];
		ground_sense    = 1'b0;
		internal_enable = '0;
		if (code >= CH_INTERNAL_LO) begin
			// Bit 0 op-amp, 1 ground, 2 temperature, 3-4 DACs, 5-6 buffers.
			internal_enable[3'(code - CH_INTERNAL_LO)] = 1'b1;
		end else if (code == CH_GROUND_SENSE) begin
			ground_sense = !NEGATIVE_SIDE;
		end else if (code <= CH_PORTA_LAST) begin
			pin_enable = 1'b1;
		end else if (code >= CH_PORTB_FIRST && code <= CH_PORTC_LAST) begin
			pin_enable = 1'b1;
		end
		// Every other code leaves all switches open.
	end

endmodule

/* File: verilog/stage_timer.sv */
// Down counter that times one conversion stage in selected clock ticks.
`timescale 1ns/1ps
module stage_timer
	import adc_select_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_sync_n,
	input  wire logic               clk_en,
	input  wire logic               load,
	input  wire logic [STAGE_W-1:0] length,
	input  wire logic               tick,
	output logic                    done
);

	logic [STAGE_W-1:0] remain_q;

	// Done when the last remaining tick arrives.
	assign done = tick && remain_q == 14'h0001;

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			remain_q <= '0;
		end else if (clk_en) begin
			if (load) begin
				remain_q <= length;
			end else if (tick && remain_q != '0) begin
				remain_q <= remain_q - 14'h0001;
			end
		end
	end

endmodule

/* File: verif/adc_select_checker.sv */
// Port assertions for the converter input select and stage timing block.
`timescale 1ns/1ps
module adc_select_checker
	import adc_select_pkg::*;
#(
	parameter int CONVERT_CYCLES = 16
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       clk_en,
	input wire logic       read,
	input wire logic       write,
	input wire logic       waitrequest,
	input wire logic       vref_to_supply,
	input wire logic       vref_to_external,
	input wire logic       vref_to_fixed,
	input wire logic       pos_pin_enable,
	input wire logic [4:0] pos_pin_index,
	input wire logic       pos_ground_sense,
	input wire logic [6:0] pos_internal_enable,
	input wire logic       neg_pin_enable,
	input wire logic [4:0] neg_pin_index,
	input wire logic [6:0] neg_internal_enable,
	input wire logic       precharge_active,
	input wire logic       sample_active,
	input wire logic       convert_active,
	input wire logic       cycle_done
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [15:0] conv_cnt_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			conv_cnt_q <= 16'h0000;
		else if (convert_active)
			conv_cnt_q <= conv_cnt_q + 16'h0001;
		else
			conv_cnt_q <= 16'h0000;
	end
	property p_wait_one;
		$rose(read || write) && clk_en |-> waitrequest ##1 waitrequest == !clk_en;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait");
	property p_wait_req;
		waitrequest |-> (read || write);
	endproperty
	a_wait_req: assert property (p_wait_req) else $error("wait without request");
	property p_vref_onehot;
		$onehot0({vref_to_supply, vref_to_external, vref_to_fixed});
	endproperty
	a_vref_onehot: assert property (p_vref_onehot) else $error("two references");
	property p_stage_onehot;
		$onehot0({precharge_active, sample_active, convert_active});
	endproperty
	a_stage_onehot: assert property (p_stage_onehot) else $error("stages overlap");
	property p_done_last;
		cycle_done |-> convert_active ##1 !convert_active;
	endproperty
	a_done_last: assert property (p_done_last) else $error("done not at end");
	property p_conv_len;
		cycle_done |-> conv_cnt_q == 16'(CONVERT_CYCLES - 1);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("convert length wrong");
	property p_pos_internal;
		pos_internal_enable != 7'h00 |-> $onehot(pos_internal_enable) && !pos_pin_enable;
	endproperty
	a_pos_internal: assert property (p_pos_internal) else $error("positive clash");
	property p_neg_internal;
		neg_internal_enable != 7'h00 |-> $onehot(neg_internal_enable) && !neg_pin_enable;
	endproperty
	a_neg_internal: assert property (p_neg_internal) else $error("negative clash");
	property p_pos_pins;
		pos_pin_enable |-> pos_pin_index <= 5'h05 || pos_pin_index inside {[5'h0c:5'h17]};
	endproperty
	a_pos_pins: assert property (p_pos_pins) else $error("positive pin out of range");
	property p_neg_pins;
		neg_pin_enable |-> neg_pin_index inside {[5'h00:5'h02], 5'h04, 5'h05, [5'h0c:5'h17]};
	endproperty
	a_neg_pins: assert property (p_neg_pins) else $error("negative pin out of range");
	property p_ground_idx;
		pos_ground_sense |-> pos_pin_index == 5'h03 && pos_internal_enable == 7'h00;
	endproperty
	a_ground_idx: assert property (p_ground_idx) else $error("ground sense code");
	c_done: cover property (cycle_done);
	c_pre: cover property ($rose(precharge_active));
	c_ack: cover property (read && !waitrequest);
endmodule

bind adc_input_select_timing adc_select_checker #(.CONVERT_CYCLES(CONVERT_CYCLES)) i_adc_select_checker (
	.clk, .rst_n, .clk_en, .read, .write, .waitrequest, .vref_to_supply, .vref_to_external,
	.vref_to_fixed, .pos_pin_enable, .pos_pin_index, .pos_ground_sense, .pos_internal_enable,
	.neg_pin_enable, .neg_pin_index, .neg_internal_enable, .precharge_active, .sample_active,
	.convert_active, .cycle_done);

/* File: verif/analog_front_model.sv */
// Analog front end model: RC timing oscillator and a positive source clash monitor.
`timescale 1ns/1ps
module analog_front_model
	import adc_select_pkg::*;
#(
	parameter int RC_HALF = 3
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       pos_pin_enable,
	input wire logic       pos_ground_sense,
	input wire logic [6:0] pos_internal_enable,
	output logic           dedicated_rc_clock,
	output logic           conflict
);
	// The oscillator runs free; it is kept slower than half the system clock.
	int rc_cnt;
	initial begin
		rc_cnt = 0;
		dedicated_rc_clock = 1'b0;
		conflict = 1'b0;
	end
	always @(posedge clk) begin
		rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
		if (rc_cnt == RC_HALF - 1)
			dedicated_rc_clock <= !dedicated_rc_clock;
		if (rst_n && pos_internal_enable != 7'h00 && (pos_pin_enable || pos_ground_sense))
			conflict <= 1'b1;
	end
endmodule

/* File: verif/adc_input_select_timing_tb_top.sv */
// Self-checking bench for the converter input select and stage timing block.
`timescale 1ns/1ps
module adc_input_select_timing_tb_top;
	import adc_select_pkg::*;
	// ------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------
	logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, ce = 1'b1, rc, conflict;
	logic [15:0] address = 16'h0000;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0, readdata;
	logic waitrequest, v_s, v_e, v_f, p_en, p_gs, n_en, pre_a, smp_a, conv_a, done;
	logic [4:0] p_idx, n_idx;
	logic [6:0] p_int, n_int;
	logic [31:0] exp_q[$];
	localparam logic [13:0] IDX_LIST [7] = '{IDX_POS_CHANNEL, IDX_NEG_CHANNEL, IDX_ACQUISITION,
		IDX_PRECHARGE, IDX_REFERENCE, IDX_CONTROL, IDX_STATUS};
	int pre_q[$], acq_q[$];
	int err_count = 0, cmp_count = 0, pre_n = 0, acq_n = 0, conv_n = 0, done_seen = 0;
	int seed = 32'hf69c0c90, e;
	logic rc_mode = 1'b0, rc_prev = 1'b0, tick;
	always #10 clk = ~clk;
	always @(posedge clk) ce <= cmp_count inside {[1:5]} ? 1'($random(seed)) : 1'b1;
	adc_input_select_timing #(.CONVERT_CYCLES(4)) i_adc_input_select_timing (
		.clk, .rst_n, .clk_en(ce), .address, .read, .write, .byteenable, .writedata,
		.readdata, .waitrequest, .dedicated_rc_clock(rc), .vref_to_supply(v_s),
		.vref_to_external(v_e), .vref_to_fixed(v_f), .pos_pin_enable(p_en),
		.pos_pin_index(p_idx), .pos_ground_sense(p_gs), .pos_internal_enable(p_int),
		.neg_pin_enable(n_en), .neg_pin_index(n_idx), .neg_internal_enable(n_int),
		.precharge_active(pre_a), .sample_active(smp_a), .convert_active(conv_a),
		.cycle_done(done));
	analog_front_model i_analog_front_model (.clk, .rst_n, .pos_pin_enable(p_en),
		.pos_ground_sense(p_gs), .pos_internal_enable(p_int), .dedicated_rc_clock(rc), .conflict);
	// ------------------------------------------------------------------
	// Tasks and monitors
	// ------------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] expv);
		cmp_count++;
		if (seen !== expv) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task bus(input logic wr, input logic [13:0] idx, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= {idx, 2'b00};
		writedata <= d;
		byteenable <= be;
		@(negedge clk);
		while (waitrequest !== 1'b0) @(negedge clk);
		@(posedge clk);
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task rd(input logic [13:0] idx, input logic [31:0] expv);
		exp_q.push_back(expv);
		bus(1'b0, idx, 32'h0, 4'hf);
	endtask
	task start(input int pre, input int acquisition_count, input logic rcs);
		bus(1'b1, IDX_ACQUISITION, 32'(acquisition_count), 4'hf);
		bus(1'b1, IDX_PRECHARGE, 32'(pre), 4'hf);
		pre_q.push_back(pre);
		acq_q.push_back(acquisition_count != 0 ? acquisition_count : (pre != 0 ? 8192 : 0));
		rc_mode = rcs;
		bus(1'b1, IDX_CONTROL, {30'h0, rcs, 1'b1}, 4'hf);
	endtask
	task finish_cycle;
		int d0;
		d0 = done_seen;
		wait (done_seen != d0);
		$display("test cycle done");
	endtask
	always @(negedge clk) begin
		tick = rc_mode ? (rc && !rc_prev) : 1'b1;
		rc_prev = rc;
		if (read === 1'b1 && waitrequest === 1'b0)
			check(readdata, exp_q.pop_front());
		if (pre_a === 1'b1) pre_n += tick;
		if (smp_a === 1'b1) acq_n += tick;
		if (conv_a === 1'b1) conv_n++;
		if (done === 1'b1) begin
			e = pre_q.pop_front();
			check(pre_n >= e && pre_n <= e + (e != 0), 1);
			e = acq_q.pop_front();
			check(acq_n >= e && acq_n <= e + (e != 0), 1);
			check(conv_n, 4);
			pre_n = 0;
			acq_n = 0;
			conv_n = 0;
			done_seen++;
		end
	end
	initial begin
		#1200000;
		err_count++;
		final_report;
	end
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		int c, p;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(negedge clk);
		check({v_f, v_e, v_s, p_en, p_idx, n_en, n_idx}, {3'b001, 6'h20, 6'h20});
		foreach (IDX_LIST[i]) rd(IDX_LIST[i], 32'h0);
		$display("test reset done");
		bus(1'b1, IDX_PRECHARGE, 32'hffffffff, 4'hf);
		rd(IDX_PRECHARGE, 32'h1fff);
		bus(1'b1, IDX_ACQUISITION, 32'hffffff55, 4'h1);
		bus(1'b1, IDX_ACQUISITION, 32'hfffff5ff, 4'h2);
		rd(IDX_ACQUISITION, 32'h1555);
		bus(1'b1, 14'h1d22, 32'hffffffff, 4'hf);
		rd(14'h1d22, 32'h0);
		$display("test registers done");
		for (c = 0; c < 4; c++) begin
			bus(1'b1, IDX_REFERENCE, 32'(c), 4'hf);
			repeat (2) @(posedge clk);
			check({v_f, v_e, v_s}, c == 3 ? 3'b100 : c == 2 ? 3'b010 : c == 0 ? 3'b001 : 0);
		end
		$display("test reference done");
		for (c = 0; c < 64; c++) begin
			bus(1'b1, IDX_POS_CHANNEL, 32'(c), 4'hf);
			bus(1'b1, IDX_NEG_CHANNEL, 32'(c), 4'hf);
			repeat (2) @(posedge clk);
			p = ((c <= 5 && c != 3) || (c >= 12 && c <= 23)) ? 1 : 0;
			e = c >= 57 ? 1 << (c - 57) : 0;
			check({p_en, p_en ? p_idx : 5'h0, p_gs, p_int},
				{p[0], p ? 5'(c) : 5'h0, c == 3, 7'(e)});
			check({n_en, n_en ? n_idx : 5'h0, n_int},
				{p[0], p ? 5'(c) : 5'h0, 7'(e)});
		end
		check(conflict, 1'b0);
		$display("test channels done");
		start((($random(seed) & 32'h0f) + 1), (($random(seed) & 32'h0f) + 1), 1'b0);
		finish_cycle;
		start(0, 7, 1'b0);
		finish_cycle;
		start(0, 0, 1'b0);
		finish_cycle;
		start(3, 0, 1'b0);
		finish_cycle;
		start(4, 5, 1'b1);
		finish_cycle;
		start(5, 3, 1'b0);
		bus(1'b1, IDX_PRECHARGE, 32'h9, 4'hf);
		bus(1'b1, IDX_ACQUISITION, 32'h2, 4'hf);
		finish_cycle;
		final_report;
	end
endmodule
